// file: rtl/eied_defs.svh
// constants for the external interrupt edge detector
// assumes inclusion by bare name from every design file that needs it
`ifndef EIED_DEFS_SVH
`define EIED_DEFS_SVH

// lane numbering inside the block
`define EIED_LANES 4
`define EIED_LANE_A 0
`define EIED_LANE_B 1
`define EIED_LANE_C 2
`define EIED_LANE_D 3

// trigger-type bit positions in the timer control byte
`define EIED_TT_A_BIT 0
`define EIED_TT_B_BIT 2

// port c bit positions of each lane's pin
`define EIED_PORT_BIT_A 2
`define EIED_PORT_BIT_B 3
`define EIED_PORT_BIT_C 6
`define EIED_PORT_BIT_D 7

// reset values
`define EIED_PIN_IDLE 4'hf
`define EIED_LANES_ZERO 4'h0
`define EIED_PORT_ZERO 8'h00

// lanes able to leave power-down (b, c and d)
`define EIED_WAKE_MASK 4'he

`endif

// file: rtl/eied_pkg.sv
// types shared by the external interrupt edge detector files
// assumes eied_defs.svh for widths
`default_nettype none
`include "eied_defs.svh"

package eied_pkg;

  // power state, gray coded along run -> down -> wake
  typedef enum logic [1:0] {
    EIED_RUN = 2'b00,
    EIED_DOWN = 2'b01,
    EIED_WAKE = 2'b11
  } eied_pwr_type;

  typedef struct packed {
    logic [`EIED_LANES-1:0] stage1;
    logic [`EIED_LANES-1:0] stage2;
  } eied_sync_type;

  typedef struct packed {
    logic [`EIED_LANES-1:0] prev;
    logic [`EIED_LANES-1:0] pulse;
  } eied_edge_type;

  typedef struct packed {
    eied_pwr_type pwr;
    logic [`EIED_LANES-1:0] flag;
    logic [`EIED_LANES-1:0] overrun;
    logic [`EIED_LANES-1:0] wake_src;
    logic wake_pulse;
    logic [`EIED_LANES-1:0] pin_out;
    logic [`EIED_LANES-1:0] pin_oe_n;
    logic rxd_alt;
    logic [7:0] port_sample;
  } eied_main_type;

endpackage
`default_nettype wire

// file: rtl/eied_sync.sv
// two-flop synchroniser for the four interrupt pins
// assumes pins idle high and are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "eied_defs.svh"

module eied_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // raw pins and synchronised levels
  input wire logic [`EIED_LANES-1:0] raw_in,
  output logic [`EIED_LANES-1:0] sync_out
);

  eied_pkg::eied_sync_type st_r;
  eied_pkg::eied_sync_type st_nxt;

  // first stage is read only by the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.stage1 = raw_in;
    st_nxt.stage2 = st_r.stage1;
  end

  // idle-high reset so no false edge after release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= {`EIED_PIN_IDLE, `EIED_PIN_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stage2;

endmodule
`default_nettype wire

// file: rtl/eied_edge.sv
// per-lane edge detector, falling only or both edges
// assumes levels already synchronised to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "eied_defs.svh"

module eied_edge (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // level and edge selection
  input wire logic [`EIED_LANES-1:0] level,
  input wire logic [`EIED_LANES-1:0] falling_only,
  // one pulse per transition, none for rises in falling-only lanes
  output logic [`EIED_LANES-1:0] edge_pulse
);

  eied_pkg::eied_edge_type st_r;
  eied_pkg::eied_edge_type st_nxt;

  // compare with previous sample; rises masked in falling-only lanes
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = level;
    st_nxt.pulse = (st_r.prev & ~level) |
                   (~st_r.prev & level & ~falling_only);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= {`EIED_PIN_IDLE, `EIED_LANES_ZERO};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_pulse = st_r.pulse;

endmodule
`default_nettype wire

// file: rtl/eied_top.sv
// external interrupt edge detector for four port c pins
// assumes core logic clears flags with one-cycle pulses and drives
// the power-down request; pins come from outside the clock domain
//
// Notes on behaviour
// - lane b with its trigger bit at one flags falling edges only.
// - lane b with its trigger bit at zero flags rising and falling edges.
// - lane a with its trigger bit at one flags falling edges only.
// - lane a with its trigger bit at zero flags rising and falling edges.
// - a qualifying edge on lane b wakes the device from power-down.
// - lane c flags falling edges only, with no selection.
// - a falling edge on lane c wakes the device from power-down.
// - lane d flags falling edges only, with no selection.
// - a falling edge on lane d wakes the device from power-down.
// - the lane c pin also feeds the alternate uart receive input.
// - the lane b pin is also general-purpose port c bit three.
// - the lane c pin is also general-purpose port c bit six.
`timescale 1ns/1ps
`default_nettype none
`include "eied_defs.svh"

module eied_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // lane a pin, port c bit two
  input wire logic ext_irq_a_pin_in,
  output logic ext_irq_a_pin_out,
  output logic ext_irq_a_pin_oe_n,
  // lane b pin, port c bit three
  input wire logic port_c_bit_three_in,
  output logic port_c_bit_three_out,
  output logic port_c_bit_three_oe_n,
  // lane c pin, port c bit six
  input wire logic port_c_bit_six_in,
  output logic port_c_bit_six_out,
  output logic port_c_bit_six_oe_n,
  // lane d pin, port c bit seven
  input wire logic port_c_bit_seven_in,
  output logic port_c_bit_seven_out,
  output logic port_c_bit_seven_oe_n,
  // trigger selection from the timer control byte
  input wire logic [7:0] timer_control_reg,
  // general-purpose drive from the core, lanes a..d
  input wire logic [`EIED_LANES-1:0] gpio_out_val,
  input wire logic [`EIED_LANES-1:0] gpio_drive_en,
  // port c readback
  output logic [7:0] port_c_sample,
  // uart alternate receive path
  input wire logic uart_alt_sel,
  output logic uart_rxd_alt,
  // interrupt requests and clears
  output logic irq_a_req,
  output logic irq_b_req,
  output logic irq_c_req,
  output logic irq_d_req,
  input wire logic [`EIED_LANES-1:0] irq_clear,
  output logic [`EIED_LANES-1:0] irq_overrun,
  // power-down control
  input wire logic power_down_req,
  output logic power_down_active,
  output logic wake_pulse,
  output logic [`EIED_LANES-1:0] wake_source
);

  logic [`EIED_LANES-1:0] pins_raw;
  logic [`EIED_LANES-1:0] pins_sync;
  logic [`EIED_LANES-1:0] falling_only;
  logic [`EIED_LANES-1:0] edges;
  logic irq_a_trigger_type;
  logic irq_b_trigger_type;

  eied_pkg::eied_main_type st_r;
  eied_pkg::eied_main_type st_nxt;

  // places the four lane levels onto their port c bit positions
  function automatic logic [7:0] to_port(
    input logic [`EIED_LANES-1:0] lanes
  );
    logic [7:0] p;
    p = `EIED_PORT_ZERO;
    p[`EIED_PORT_BIT_A] = lanes[`EIED_LANE_A];
    p[`EIED_PORT_BIT_B] = lanes[`EIED_LANE_B];
    p[`EIED_PORT_BIT_C] = lanes[`EIED_LANE_C];
    p[`EIED_PORT_BIT_D] = lanes[`EIED_LANE_D];
    return p;
  endfunction

  // gather raw pin levels in lane order
  assign pins_raw[`EIED_LANE_A] = ext_irq_a_pin_in;
  assign pins_raw[`EIED_LANE_B] = port_c_bit_three_in;
  assign pins_raw[`EIED_LANE_C] = port_c_bit_six_in;
  assign pins_raw[`EIED_LANE_D] = port_c_bit_seven_in;

  eied_sync u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .raw_in (pins_raw),
    .sync_out (pins_sync)
  );

  // trigger-type bits taken straight from the control byte
  assign irq_a_trigger_type = timer_control_reg[`EIED_TT_A_BIT];
  assign irq_b_trigger_type = timer_control_reg[`EIED_TT_B_BIT];

  assign falling_only[`EIED_LANE_B] = irq_b_trigger_type;
  assign falling_only[`EIED_LANE_A] = irq_a_trigger_type;
  assign falling_only[`EIED_LANE_C] = 1'b1;
  assign falling_only[`EIED_LANE_D] = 1'b1;

  eied_edge u_edge (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .level (pins_sync),
    .falling_only (falling_only),
    .edge_pulse (edges)
  );

  // next-state logic for flags, power state and pin drive
  always_comb begin
    st_nxt = st_r;
    st_nxt.wake_pulse = 1'b0;

    st_nxt.flag = (st_r.flag & ~irq_clear) | edges;
    // an edge landing on a still-pending flag is counted as lost
    st_nxt.overrun = (st_r.overrun & ~irq_clear) |
                     (edges & st_r.flag & ~irq_clear);

    case (st_r.pwr)
      eied_pkg::EIED_RUN: begin
        if (power_down_req) begin
          st_nxt.pwr = eied_pkg::EIED_DOWN;
          st_nxt.wake_src = `EIED_LANES_ZERO;
        end
      end
      eied_pkg::EIED_DOWN: begin
        if ((edges & `EIED_WAKE_MASK) != `EIED_LANES_ZERO) begin
          st_nxt.pwr = eied_pkg::EIED_WAKE;
          st_nxt.wake_src = edges & `EIED_WAKE_MASK;
          st_nxt.wake_pulse = 1'b1;
        end
      end
      eied_pkg::EIED_WAKE: begin
        // one cycle for the core to restart before a new request counts
        st_nxt.pwr = eied_pkg::EIED_RUN;
      end
      default: begin
        st_nxt.pwr = eied_pkg::EIED_RUN;
      end
    endcase

    st_nxt.pin_out = gpio_out_val;
    st_nxt.pin_oe_n = ~gpio_drive_en;

    // alternate receive; idle high when not selected
    st_nxt.rxd_alt = uart_alt_sel ? pins_sync[`EIED_LANE_C] : 1'b1;

    st_nxt.port_sample = to_port(pins_sync);
  end

  // state register; pins released and flags clear under reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.pwr <= eied_pkg::EIED_RUN;
      st_r.flag <= `EIED_LANES_ZERO;
      st_r.overrun <= `EIED_LANES_ZERO;
      st_r.wake_src <= `EIED_LANES_ZERO;
      st_r.wake_pulse <= 1'b0;
      st_r.pin_out <= `EIED_PIN_IDLE;
      st_r.pin_oe_n <= `EIED_PIN_IDLE;
      st_r.rxd_alt <= 1'b1;
      st_r.port_sample <= `EIED_PORT_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  // request outputs, straight from the sticky flags
  assign irq_a_req = st_r.flag[`EIED_LANE_A];
  assign irq_b_req = st_r.flag[`EIED_LANE_B];
  assign irq_c_req = st_r.flag[`EIED_LANE_C];
  assign irq_d_req = st_r.flag[`EIED_LANE_D];
  assign irq_overrun = st_r.overrun;

  // pin drive outputs
  assign ext_irq_a_pin_out = st_r.pin_out[`EIED_LANE_A];
  assign ext_irq_a_pin_oe_n = st_r.pin_oe_n[`EIED_LANE_A];
  assign port_c_bit_three_out = st_r.pin_out[`EIED_LANE_B];
  assign port_c_bit_three_oe_n = st_r.pin_oe_n[`EIED_LANE_B];
  assign port_c_bit_six_out = st_r.pin_out[`EIED_LANE_C];
  assign port_c_bit_six_oe_n = st_r.pin_oe_n[`EIED_LANE_C];
  assign port_c_bit_seven_out = st_r.pin_out[`EIED_LANE_D];
  assign port_c_bit_seven_oe_n = st_r.pin_oe_n[`EIED_LANE_D];

  // misc status
  assign port_c_sample = st_r.port_sample;
  assign uart_rxd_alt = st_r.rxd_alt;
  assign power_down_active = (st_r.pwr == eied_pkg::EIED_DOWN);
  assign wake_pulse = st_r.wake_pulse;
  assign wake_source = st_r.wake_src;

endmodule
`default_nettype wire

// file: tb/eied_top_sva.sv
// edge-to-request and wake checks on the edge detector's ports
// assumes pins held steady for several cycles between transitions
`timescale 1ns/1ps
`default_nettype none
`include "eied_defs.svh"

module eied_top_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // pins and trigger byte
  input wire logic ext_irq_a_pin_in,
  input wire logic port_c_bit_three_in,
  input wire logic port_c_bit_six_in,
  input wire logic port_c_bit_seven_in,
  input wire logic [7:0] timer_control_reg,
  // requests and power state
  input wire logic irq_a_req,
  input wire logic irq_b_req,
  input wire logic irq_c_req,
  input wire logic irq_d_req,
  input wire logic power_down_active,
  input wire logic wake_pulse,
  input wire logic [`EIED_LANES-1:0] wake_source
);
  // pin sampled, two sync stages, pulse, then flag: four edges
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_c_fall_flag: assert property (
    $fell(port_c_bit_six_in) |-> ##4 irq_c_req) else $error("c fall lost");
  a_c_no_rise: assert property (
    $rose(irq_c_req) |-> !$past(port_c_bit_six_in, 4) &&
    $past(port_c_bit_six_in, 5)) else $error("c flag without fall");
  a_d_no_rise: assert property (
    $rose(irq_d_req) |-> !$past(port_c_bit_seven_in, 4) &&
    $past(port_c_bit_seven_in, 5)) else $error("d flag without fall");
  a_a_fall_mode: assert property (
    $rose(irq_a_req) && timer_control_reg[0] |->
    !$past(ext_irq_a_pin_in, 4) && $past(ext_irq_a_pin_in, 5))
    else $error("a flag without fall");
  a_a_both_edges: assert property (
    $changed(ext_irq_a_pin_in) && !timer_control_reg[0] |-> ##4 irq_a_req)
    else $error("a edge lost");
  a_b_fall_mode: assert property (
    $rose(irq_b_req) && timer_control_reg[2] |->
    !$past(port_c_bit_three_in, 4) && $past(port_c_bit_three_in, 5))
    else $error("b flag without fall");
  a_b_both_edges: assert property (
    $changed(port_c_bit_three_in) && !timer_control_reg[2] |-> ##4 irq_b_req)
    else $error("b edge lost");
  a_wake_by_b: assert property (
    power_down_active && timer_control_reg[2] && $fell(port_c_bit_three_in)
    |-> ##4 wake_pulse && !power_down_active && wake_source[1])
    else $error("b did not wake");
  a_wake_by_c: assert property (
    power_down_active && $fell(port_c_bit_six_in) |->
    ##4 wake_pulse && !power_down_active && wake_source[2])
    else $error("c did not wake");
  a_wake_by_d: assert property (
    power_down_active && $fell(port_c_bit_seven_in) |->
    ##4 wake_pulse && !power_down_active && wake_source[3])
    else $error("d did not wake");

  // main scenarios reached
  c_wake_b: cover property (wake_pulse && wake_source[1]);
  c_a_both: cover property ($rose(irq_a_req) && !timer_control_reg[0]);
  c_d_flag: cover property ($rose(irq_d_req));
endmodule

bind eied_top eied_top_sva eied_top_sva_inst (.sys_clk, .reset_n,
  .ext_irq_a_pin_in, .port_c_bit_three_in, .port_c_bit_six_in,
  .port_c_bit_seven_in, .timer_control_reg, .irq_a_req, .irq_b_req,
  .irq_c_req, .irq_d_req, .power_down_active, .wake_pulse, .wake_source);
`default_nettype wire

// file: tb/eied_src_model.sv
// outside signal sources with pull-ups on the four lane pins
// assumes the design's own drive overrides the weak source
`timescale 1ns/1ps
`default_nettype none

module eied_src_model (
  // design drive per lane
  input wire logic [3:0] drv_val,
  input wire logic [3:0] drv_oe_n,
  // outside source levels, idle high
  input wire logic [3:0] src_level,
  // resolved pin levels
  output logic [3:0] pin_level
);
  // wired level seen by every input of the pin
  assign pin_level = (drv_val & ~drv_oe_n) | (src_level & drv_oe_n);
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the edge detector
// assumes the source model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "eied_defs.svh"

module tb;
  logic sys_clk, reset_n, uart_alt_sel, uart_rxd_alt, wake_pulse;
  logic power_down_req, power_down_active;
  logic [7:0] timer_control_reg, port_c_sample, seed, exp_v;
  logic [3:0] gpio_out_val, gpio_drive_en, irq_clear, src, pins, outs, oe_n;
  logic [3:0] flg, flg_q, wake_source, ovr;
  int err_total = 0;
  int samples_checked = 0;
  int exp_q[$];

  eied_top eied_top_inst (.sys_clk, .reset_n, .ext_irq_a_pin_in(pins[0]),
    .ext_irq_a_pin_out(outs[0]), .ext_irq_a_pin_oe_n(oe_n[0]),
    .port_c_bit_three_in(pins[1]), .port_c_bit_three_out(outs[1]),
    .port_c_bit_three_oe_n(oe_n[1]), .port_c_bit_six_in(pins[2]),
    .port_c_bit_six_out(outs[2]), .port_c_bit_six_oe_n(oe_n[2]),
    .port_c_bit_seven_in(pins[3]), .port_c_bit_seven_out(outs[3]),
    .port_c_bit_seven_oe_n(oe_n[3]), .timer_control_reg, .gpio_out_val,
    .gpio_drive_en, .port_c_sample, .uart_alt_sel, .uart_rxd_alt,
    .irq_a_req(flg[0]), .irq_b_req(flg[1]), .irq_c_req(flg[2]),
    .irq_d_req(flg[3]), .irq_clear, .irq_overrun(ovr), .power_down_req,
    .power_down_active, .wake_pulse, .wake_source);
  eied_src_model eied_src_model_inst (.drv_val(outs), .drv_oe_n(oe_n),
    .src_level(src), .pin_level(pins));

  // 20 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // toggle one source, note the request it should give, then clear
  task automatic flip(int k);
    logic trig;
    src[k] = ~src[k];
    trig = (k == 0) ? timer_control_reg[0] : timer_control_reg[2];
    if (!src[k] || (k < 2 && !trig)) exp_q.push_back(k);
    tick(8);
    irq_clear = 4'hf;
    tick(1);
    irq_clear = 4'h0;
    tick(1);
    check("pending", 8'(exp_q.size()), 8'h00);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // each new request takes the oldest note off the queue
  always @(posedge sys_clk) begin
    flg_q <= flg;
    if (reset_n && (flg & ~flg_q) != 4'h0) begin
      if (exp_q.size() == 0) begin
        check("stray req", 8'(flg & ~flg_q), 8'h00);
      end else begin
        check("req", 8'(flg & ~flg_q), 8'h01 << exp_q.pop_front());
      end
    end
  end

  // hang guard, far beyond the some 640 cycles needed
  initial begin
    #1000000;
    err_total++;
    close_out();
  end

  initial begin
    reset_n = 0;
    uart_alt_sel = 0;
    power_down_req = 0;
    timer_control_reg = 8'h00;
    gpio_out_val = 4'hf;
    gpio_drive_en = 4'h0;
    irq_clear = 4'h0;
    src = 4'hf;
    seed = 8'h47;
    repeat (20) @(posedge sys_clk);
    #1 reset_n = 1;
    tick(2);
    // random single edges in all four trigger modes
    for (int m = 0; m < 4; m++) begin
      timer_control_reg = {5'h00, m[1], 1'b0, m[0]};
      uart_alt_sel = m[0];
      for (int i = 0; i < 12; i++) begin
        seed = lfsr(seed);
        gpio_out_val = seed[7:4];
        flip(int'(seed[1:0]));
        exp_v = {src[3:2], 2'b00, src[1:0], 2'b00};
        check("port c", port_c_sample, exp_v);
        exp_v = 8'(uart_alt_sel ? src[2] : 1'b1);
        check("uart rx", 8'(uart_rxd_alt), exp_v);
      end
    end
    // power-down left by each lane's falling edge; lane a must not wake
    timer_control_reg = 8'h05;
    // park sources high so every first flip below is a falling edge
    src = 4'hf;
    tick(4);
    for (int k = 3; k >= 0; k--) begin
      power_down_req = 1;
      tick(1);
      power_down_req = 0;
      tick(1);
      check("down", 8'(power_down_active), 8'h01);
      flip(k);
      check("wake", 8'(wake_source), 8'(k ? 1 << k : 0));
      check("asleep", 8'(power_down_active), 8'(k == 0));
      if (k == 0) begin
        flip(2);
        flip(2);
      end
      flip(k);
    end
    // core drives all pins, then pulls lane d low itself
    gpio_out_val = 4'hf;
    gpio_drive_en = 4'hf;
    tick(2);
    check("drive oe", 8'(oe_n), 8'h00);
    check("drive val", 8'(outs), 8'h0f);
    exp_q.push_back(3);
    gpio_out_val = 4'h7;
    tick(8);
    check("port drv", port_c_sample, 8'h4c);
    check("pending", 8'(exp_q.size()), 8'h00);
    // second fall on lane d while its flag is still pending
    gpio_out_val = 4'hf;
    tick(4);
    gpio_out_val = 4'h7;
    tick(8);
    check("overrun", 8'(ovr), 8'h08);
    check("d held", 8'(flg), 8'h08);
    close_out();
  end
endmodule
`default_nettype wire
